// ### verilog/arc_readout.sv
`timescale 1ns/100ps
`include "arc_params.svh"

// Result buffer with valid/ready on both sides
module arc_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);  // Pointer width

  // Lets the core hand over results before the host reads them.
  // Ready is registered, so the core sees no path through the pins.
  logic [WIDTH-1:0] mem [DEPTH];  // Storage words
  logic [AW-1:0]    wr_ptr;       // Write position
  logic [AW-1:0]    rd_ptr;       // Read position
  logic [AW:0]      count;        // Words held
  logic             push;         // Word accepted this cycle
  logic             pop;          // Word taken this cycle

  // Handshakes on both sides; read data shows the oldest word
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  // Storage write
  // No reset on storage: a word is only read once it is valid
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers, fill level and registered ready
  // Ready falls in the cycle the last slot fills, never later
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      count    <= '0;
      in_ready <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      case ({push, pop})
        // Push only: one more word held
        2'b10: begin
          count    <= count + 1'b1;
          in_ready <= (count + 1'b1) != (AW+1)'(DEPTH);
        end
        // Pop only: a slot is free again
        2'b01: begin
          count    <= count - 1'b1;
          in_ready <= 1'b1;
        end
        // Both or neither: fill level unchanged
        default: begin
          count    <= count;
        end
      endcase
    end
  end
endmodule

// Two-flop pin synchroniser with one history flop for edge finding
module arc_pin_sync #(
  parameter logic RESET_LEVEL = 1'b0
) (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic pin,
  output logic      level,
  output logic      prev
);
  logic [2:0] stages;  // Two synchroniser flops, then history

  // Shift the pin through the chain; reset to the pin's idle level
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      stages <= {3{RESET_LEVEL}};
    end else begin
      stages <= {stages[1:0], pin};
    end
  end

  // Only the second flop and the history flop are read
  assign level = stages[1];
  assign prev  = stages[2];
endmodule

// Serial result readout of the converter
// The host drives the three link inputs; this block samples them on its own clock.
// Modes, except select-mode busy, are fixed at each start edge and kept until the next one.
// Results come from the core through the buffer, one per conversion.
module arc_readout (
  input  wire logic                 ref_clk,
  input  wire logic                 reset_n,
  input  wire logic                 convert_start,
  input  wire logic                 serial_in,
  input  wire logic                 serial_clk,
  output logic                      serial_out,
  output logic                      serial_out_en,
  output logic                      sample_pulse,
  input  wire logic                 result_valid,
  input  wire arc_pkg::arc_result_t result_data,
  output logic                      result_ready
);
  import arc_pkg::*;

  // Pin levels after the synchronisers, and the same one cycle earlier
  logic              cnv_lvl;         // Conversion-start level
  logic              cnv_prev;        // Conversion-start history
  logic              sdi_lvl;         // Serial input level
  logic              sdi_prev;        // Serial input history
  logic              sck_lvl;         // Link clock level
  logic              sck_prev;        // Link clock history
  // Edges found from level and history
  logic              cnv_rise;        // Start edge
  logic              sdi_rise;        // Select line released
  logic              sck_fall;        // Shift edge of the link clock
  // Sequencing
  arc_state_t        state;           // Sequencer state
  arc_mode_t         mode;            // Latched mode
  logic [9:0]        conv_cnt;        // Conversion timer
  // Readback
  logic [18:0]       shreg;           // Output shift register, start bit on top
  logic [4:0]        edge_cnt;        // Falling edges seen in readback
  logic              done_busy;       // Busy indicator active for this readback
  logic [4:0]        edge_limit;      // Falling edges that end a select readback
  // Result buffer side
  logic              fifo_pop;        // Word taken at completion
  logic              fifo_valid;      // Buffer holds a word
  arc_result_t       fifo_data;       // Oldest buffered word

  // Every pin passes two flops before use; the third flop feeds edge finding.
  // The pins come from the host's domain, so nothing reads them raw.
  arc_pin_sync #(
    .RESET_LEVEL (1'b0)
  ) u_sync_cnv (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .pin     (convert_start),
    .level   (cnv_lvl),
    .prev    (cnv_prev)
  );

  // Serial input: mode select, select line and chain data
  arc_pin_sync #(
    .RESET_LEVEL (1'b0)
  ) u_sync_sdi (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .pin     (serial_in),
    .level   (sdi_lvl),
    .prev    (sdi_prev)
  );

  // Link clock: only its level at the start edge and its falls matter
  arc_pin_sync #(
    .RESET_LEVEL (1'b0)
  ) u_sync_sck (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .pin     (serial_clk),
    .level   (sck_lvl),
    .prev    (sck_prev)
  );

  // A rise is high now and low a cycle ago; the link clock shifts on its fall
  assign cnv_rise   = cnv_lvl && !cnv_prev;
  assign sdi_rise   = sdi_lvl && !sdi_prev;
  assign sck_fall   = !sck_lvl && sck_prev;
  // Busy readbacks carry one extra start bit ahead of the result
  assign edge_limit = done_busy ? `ARC_EDGES_BUSY : `ARC_EDGES_PLAIN;

  // Results enter through the buffer, popped at conversion completion
  // A word pushed early simply waits; a late word delays completion
  arc_fifo #(
    .WIDTH ($bits(arc_result_t)),
    .DEPTH (`ARC_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .in_valid  (result_valid),
    .in_ready  (result_ready),
    .in_data   (result_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // Take the word in the cycle the sequencer enters readback;
  // a fresh start edge wins, so no word is lost to a cut conversion
  assign fifo_pop = (state == ARC_WAIT_DATA) && fifo_valid && !cnv_rise;

  // Mode capture at the start edge
  // Serial input picks select or chain; in chain mode the link clock level picks busy
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode <= '0;
    end else if (cnv_rise) begin
      mode.chain <= !sdi_lvl;                   // see RULE19
      mode.busy  <= !sdi_lvl && sck_lvl;        // see RULE11 see RULE16
    end
  end

  // Sample request to the converter core
  // One cycle wide, one per detected start edge
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sample_pulse <= 1'b0;
    end else begin
      sample_pulse <= cnv_rise;
    end
  end

  // Sequencer, conversion timer and edge counting
  // Convert for a fixed time, wait for a result, then read it back.
  // Select readbacks end on their own; chain readbacks end with the start line.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state     <= ARC_IDLE;
      conv_cnt  <= 10'h0;
      edge_cnt  <= 5'h0;
      done_busy <= 1'b0;
    end else if (cnv_rise) begin
      // A start edge always begins a new conversion
      state    <= ARC_CONVERT;                  // see RULE1
      conv_cnt <= 10'h0;
      edge_cnt <= 5'h0;
    end else begin
      case (state)
        // Fixed conversion time; only a new start edge cuts it short
        ARC_CONVERT: begin
          if (conv_cnt == 10'(`ARC_CONV_CYCLES - 1)) begin
            state <= ARC_WAIT_DATA;
          end else begin
            conv_cnt <= conv_cnt + 10'h1;
          end
        end
        ARC_WAIT_DATA: begin
          // Completion: busy in select mode if either select line is low
          if (fifo_valid) begin
            state     <= ARC_READ;              // see RULE6
            done_busy <= mode.chain ? mode.busy : (!cnv_lvl || !sdi_lvl);
            edge_cnt  <= 5'h0;
          end
        end
        // Readback: count falls, leave on the select line or last edge.
        // The edge counter saturates so a long chain burst cannot wrap it.
        ARC_READ: begin
          if (!mode.chain && sdi_rise) begin
            state <= ARC_IDLE;                  // see RULE9
          end else if (mode.chain && !cnv_lvl) begin
            state <= ARC_IDLE;
          end else if (sck_fall) begin
            if (edge_cnt != 5'h1f) begin
              edge_cnt <= edge_cnt + 5'h1;
            end
            if (!mode.chain && (edge_cnt + 5'h1 == edge_limit)) begin
              state <= ARC_IDLE;                // see RULE9 see RULE20
            end
          end
        end
        default: begin
          state <= ARC_IDLE;
        end
      endcase
    end
  end

  // Shift register: parallel load at completion, shift on falling edges
  // Bit 18 always drives the pin; busy modes put the start bit there.
  // Without a start bit the result sits one place up, above a pad bit.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      shreg <= 19'h0;
    end else if (fifo_pop) begin
      if (mode.chain && mode.busy) begin
        shreg <= {1'b1, fifo_data.code};        // see RULE17 see RULE21
      end else if (!mode.chain && (!cnv_lvl || !sdi_lvl)) begin
        shreg <= {1'b0, fifo_data.code};        // see RULE21
      end else begin
        shreg <= {fifo_data.code, 1'b0};        // see RULE13 see RULE21
      end
    end else if (state == ARC_READ && sck_fall) begin
      // Chain mode takes upstream data in right behind the own result
      if (mode.chain && !mode.busy) begin
        // Eighteen-bit chain: the pad bit below the result is skipped
        shreg <= {shreg[17:1], sdi_lvl, 1'b0};                // see RULE14
      end else begin
        shreg <= {shreg[17:0], mode.chain ? sdi_lvl : 1'b0};  // see RULE7 see RULE14
      end
    end
  end

  // Output pin drive: changes only on falling edges while reading
  // The enable is high only while this block drives the pin.
  // Both outputs are flops, so the pin never glitches on a decode.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      serial_out    <= 1'b0;
      serial_out_en <= 1'b0;
    end else if (cnv_rise || state == ARC_CONVERT || state == ARC_WAIT_DATA) begin
      // Floating while converting
      serial_out    <= 1'b0;
      serial_out_en <= 1'b0;                    // see RULE1
    end else if (state == ARC_READ) begin
      if (mode.chain || done_busy || !sdi_lvl) begin
        // Busy start bit or data bit, held between falling edges
        serial_out    <= shreg[18];             // see RULE5 see RULE8
        serial_out_en <= 1'b1;
      end else begin
        serial_out    <= 1'b0;
        serial_out_en <= 1'b0;
      end
    end else begin
      // Idle: both select lines low drive the pin low
      serial_out    <= 1'b0;
      serial_out_en <= !cnv_lvl && !sdi_lvl;    // see RULE3
    end
  end
endmodule

// ### verilog/arc_params.svh
// Overview of operation
// RULE1: Serial_in high at start edge: select mode, float
// RULE2: Host holds convert_start high through conversion, readback
// RULE3: Both inputs low drive serial_out low
// RULE4: Host lowers serial_in early for busy indicator
// RULE5: Select-mode busy: output driven at conversion end
// RULE6: After conversion, standby until next start edge
// RULE7: Shift result MSB first on falling clock
// RULE8: Output bit held across both clock edges
// RULE9: Busy select mode floats after 19th edge
// RULE10: Host should capture on falling clock edge
// RULE11: Clock low at start: chain mode, no busy
// RULE12: Host holds convert_start high in chain readback
// RULE13: Chain without busy shows MSB at completion
// RULE14: Chain mode shifts serial_in in each falling edge
// RULE15: Host gives eighteen clocks per chained device
// RULE16: Clock high at start: chain mode with busy
// RULE17: Chain busy drives output high when done
// RULE18: Host gives eighteen per device plus one
// RULE19: Serial_in level at start edge selects mode
// RULE20: Result eighteen bits; float after eighteenth edge
// RULE21: Load result in parallel at conversion completion
`ifndef ARC_PARAMS_SVH
`define ARC_PARAMS_SVH

// Result width and edge counts of one readback
`define ARC_RESULT_W      18
`define ARC_EDGES_PLAIN   5'h12
`define ARC_EDGES_BUSY    5'h13

// Conversion time and its cycle count at 40 MHz (longest time rounds down)
`define ARC_T_CONV_NS     500
`define ARC_CLK_PERIOD_NS 25
`define ARC_CONV_CYCLES   (`ARC_T_CONV_NS / `ARC_CLK_PERIOD_NS)

// Result buffer shape
`define ARC_FIFO_DEPTH    8

`endif

// ### verilog/arc_pkg.sv
package arc_pkg;

  // One conversion result as it leaves the converter core
  typedef struct packed {
    logic [17:0] code;
  } arc_result_t;

  // Sequencing states of the readout
  typedef enum logic [1:0] {
    ARC_IDLE,
    ARC_CONVERT,
    ARC_WAIT_DATA,
    ARC_READ
  } arc_state_t;

  // Mode latched at the start edge
  typedef struct packed {
    logic chain;
    logic busy;
  } arc_mode_t;

endpackage

// ### bench/arc_readout_monitor.sv
`timescale 1ns/100ps
// Pin-level checks on the readout, all in the ref_clk domain
module arc_readout_monitor (
  input wire logic                 ref_clk,
  input wire logic                 reset_n,
  input wire logic                 convert_start,
  input wire logic                 serial_in,
  input wire logic                 serial_clk,
  input wire logic                 serial_out,
  input wire logic                 serial_out_en,
  input wire logic                 sample_pulse,
  input wire logic                 result_valid,
  input wire arc_pkg::arc_result_t result_data,
  input wire logic                 result_ready
);
  import arc_pkg::*;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  // Start edge with select level, and with chain level
  sequence s_sel_start;
    $rose(convert_start) && serial_in;
  endsequence
  sequence s_chain_start;
    $rose(convert_start) && !serial_in;
  endsequence
  // Driven high: the chain busy start bit
  sequence s_done_high;
    serial_out_en && serial_out;
  endsequence
  a_start_floats: assert property (s_sel_start |-> ##5 !serial_out_en [*8])
    else $error("Output not floating after select start");
  a_idle_low: assert property (
    (!convert_start && !serial_in) [*6] |-> serial_out_en && !serial_out)
    else $error("Idle output not driven low");
  a_pulse_time: assert property ($rose(convert_start) |-> ##[2:5] sample_pulse)
    else $error("No sample pulse after start edge");
  a_pulse_single: assert property (sample_pulse |=> !sample_pulse)
    else $error("Sample pulse longer than one cycle");
  a_no_idle_pulse: assert property (!convert_start [*5] |-> !sample_pulse)
    else $error("Sample pulse without start edge");
  a_hold_on_fall: assert property ($fell(serial_clk) |-> $stable(serial_out) [*2])
    else $error("Output bit changed at falling edge");
  a_chain_busy: assert property (
    s_chain_start ##0 serial_clk |-> ##[20:40] s_done_high)
    else $error("Chain busy bit not driven high");
  a_chain_plain: assert property (
    s_chain_start ##0 !serial_clk |-> ##[20:40] serial_out_en)
    else $error("Chain output not driven at completion");
endmodule

bind arc_readout arc_readout_monitor i_arc_readout_monitor (
  .ref_clk(ref_clk), .reset_n(reset_n), .convert_start(convert_start),
  .serial_in(serial_in), .serial_clk(serial_clk), .serial_out(serial_out),
  .serial_out_en(serial_out_en), .sample_pulse(sample_pulse),
  .result_valid(result_valid), .result_data(result_data), .result_ready(result_ready)
);

// ### bench/arc_host_model.sv
`timescale 1ns/100ps
// Host side: link clock in frames, data line captured before each fall
module arc_host_model (
  input  wire logic ref_clk,
  input  wire logic serial_out,
  input  wire logic serial_out_en,
  input  wire logic idle_high,
  output logic      serial_clk
);
  logic [63:0] cap;      // Captured bits, newest in bit 0
  logic        in_frame; // High while a burst runs
  wire  logic  sdo_line = serial_out_en ? serial_out : 1'b1; // Pull-up
  initial begin
    serial_clk = 1'b0;
    cap = '0;
    in_frame = 1'b0;
  end
  // Clock stands still at its idle level outside frames
  always @(posedge ref_clk) begin
    if (!in_frame) serial_clk <= idle_high;
  end
  // n periods of 200 ns, data taken at the falling edge
  task automatic clocks(input int n);
    in_frame = 1'b1;
    repeat (n) begin
      @(posedge ref_clk);
      serial_clk <= 1'b1;
      repeat (4) @(posedge ref_clk);
      cap <= {cap[62:0], sdo_line};
      serial_clk <= 1'b0;
      repeat (3) @(posedge ref_clk);
    end
    in_frame = 1'b0;
  endtask
endmodule

// ### bench/arc_readout_test.sv
`timescale 1ns/100ps
// Self-checking bench for the serial readout
module arc_readout_test;
  import arc_pkg::*;
  logic        ref_clk, reset_n, convert_start, serial_in, serial_clk, idle_high;
  logic        serial_out, serial_out_en, sample_pulse, result_valid, result_ready;
  arc_result_t result_data;
  int          err_total, n_tests;
  arc_readout i_arc_readout (.ref_clk(ref_clk), .reset_n(reset_n),
    .convert_start(convert_start), .serial_in(serial_in), .serial_clk(serial_clk),
    .serial_out(serial_out), .serial_out_en(serial_out_en), .sample_pulse(sample_pulse),
    .result_valid(result_valid), .result_data(result_data), .result_ready(result_ready));
  arc_host_model i_arc_host_model (.ref_clk(ref_clk), .serial_out(serial_out),
    .serial_out_en(serial_out_en), .idle_high(idle_high), .serial_clk(serial_clk));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic report_and_stop;
    if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Core hands one result, held until taken or for at most 20 cycles
  task automatic push(input logic [17:0] w);
    @(posedge ref_clk);
    result_valid <= 1'b1;
    result_data  <= '{code: w};
    repeat (20) begin
      @(posedge ref_clk);
      if (result_ready === 1'b1) break;
    end
    result_valid <= 1'b0;
  endtask
  task automatic start(input logic si);
    @(posedge ref_clk);
    i_arc_host_model.cap <= '0;
    serial_in     <= si;
    convert_start <= 1'b1;
  endtask
  task automatic stop_frame;
    @(posedge ref_clk);
    convert_start <= 1'b0;
    serial_in     <= 1'b0;
    wait_cyc(10);
    check(serial_out_en && !serial_out, "idle not driven low");
  endtask
  task automatic sel_plain(input logic [17:0] w);
    start(1'b1);
    wait_cyc(40);
    check(!serial_out_en, "select output not floating");
    serial_in <= 1'b0;
    wait_cyc(8);
    check(serial_out_en && serial_out === w[17], "msb not shown");
    i_arc_host_model.clocks(18);
    wait_cyc(8);
    check(i_arc_host_model.cap[17:0] === w, "select word wrong");
    check(!serial_out_en, "no float after last bit");
    stop_frame;
  endtask
  task automatic sel_busy(input logic [17:0] w, input int n);
    start(1'b1);
    wait_cyc(8);
    serial_in <= 1'b0;
    wait_cyc(40);
    check(serial_out_en && !serial_out, "no busy start bit");
    i_arc_host_model.clocks(n);
    wait_cyc(8);
    check(i_arc_host_model.cap[18:0] === ({1'b0, w} >> (19 - n)), "busy word");
    check(serial_out_en === (n < 19), "float after last bit wrong");
    serial_in <= 1'b1;
    wait_cyc(8);
    check(!serial_out_en, "no float on select rise");
    stop_frame;
  endtask
  task automatic chain(input logic [17:0] w, input logic [17:0] up, input logic busy);
    idle_high <= busy;
    wait_cyc(8);
    start(1'b0);
    wait_cyc(40);
    check(serial_out_en && serial_out === (busy | w[17]), "chain first bit");
    // Upstream word enters on the first falls and follows the own word
    for (int i = 0; i < 36 + int'(busy); i++) begin
      serial_in <= (i < 18) ? up[17 - i] : 1'b0;
      i_arc_host_model.clocks(1);
    end
    wait_cyc(8);
    check(i_arc_host_model.cap[36:0] === {busy, w, up}, "chain words wrong");
    stop_frame;
    idle_high <= 1'b0;
    wait_cyc(8);
  endtask
  task automatic fill_drain;
    for (int i = 0; i < 8; i++) push(18'h3f000 + 18'(i));
    wait_cyc(3);
    check(!result_ready, "buffer not refusing");
    for (int i = 0; i < 8; i++) sel_plain(18'h3f000 + 18'(i));
    check(result_ready, "buffer not drained");
  endtask
  initial begin
    reset_n = 1'b0;
    convert_start = 1'b0;
    serial_in = 1'b0;
    idle_high = 1'b0;
    result_valid = 1'b0;
    result_data = '0;
    err_total = 0;
    n_tests = 0;
    wait_cyc(16);
    reset_n <= 1'b1;
    wait_cyc(6);
    check(!sample_pulse && result_ready, "reset state wrong");
    push(18'h2a5c3);
    sel_plain(18'h2a5c3);
    push(18'h15a3c);
    sel_busy(18'h15a3c, 19);
    push(18'h3c00f);
    sel_busy(18'h3c00f, 5);
    push(18'h20001);
    chain(18'h20001, 18'h1e5a7, 1'b0);
    push(18'h0ff31);
    chain(18'h0ff31, 18'h2c3d5, 1'b1);
    fill_drain;
    report_and_stop;
  end
  // Cuts a hang short
  initial begin
    #1_000_000;
    err_total++;
    report_and_stop;
  end
endmodule
